// [eos_pkg.sv]
// Package for the external oscillator start-up sequencer controller
package eos_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned SETTLE_TIME_NS = 1000000;
  // Least time: round up
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 24;

  // ************************************************************
  // Frequency range codes
  // ************************************************************
  localparam logic [2:0] FREQ_XTAL_11M  = 3'h7;
  localparam logic [2:0] FREQ_WATCH_32K = 3'h1;
  localparam logic [2:0] FREQ_LOW_POWER = 3'h0;

  // ************************************************************
  // Controller register map (word addresses)
  // ************************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_WATCH_BIT = 1;
  localparam int unsigned CTRL_LOWP_BIT  = 2;
  localparam int unsigned CTRL_ABORT_BIT = 3;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_PINS_LOW,
    ST_ANALOG,
    ST_ENABLE,
    ST_WAIT,
    ST_POLL,
    ST_MCD,
    ST_SWITCH,
    ST_DONE
  } eos_state_t;

  // Device-side controls, driven as one group
  typedef struct packed {
    logic       crossbar_en;
    logic       port0_latch_bit2;
    logic       port0_latch_bit3;
    logic       pin_a_analog;
    logic       pin_b_analog;
    logic       osc_en;
    logic [2:0] ext_osc_freq_range;
    logic       missing_clk_det_en;
    logic       sysclk_sel_ext;
  } eos_dev_ctrl_t;

endpackage

// [eos_wait_timer.sv]
// Minimum-wait timer for the oscillator settling interval
`timescale 1ns/1ns
`default_nettype none
module eos_wait_timer #(
  parameter int unsigned CYCLES = eos_pkg::SETTLE_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      expired
);

  localparam int unsigned CW = eos_pkg::CNT_W;

  logic [CW-1:0] count;
  logic          running;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count   <= CW'(CYCLES - 1);
      running <= 1'b1;
      expired <= 1'b0;
    end else if (running) begin
      if (count == '0) begin
        running <= 1'b0;
        expired <= 1'b1;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [eos_controller.sv]
// Controller that brings up an external crystal and switches the system clock to it
// Contract
// - An 11.0592 MHz crystal uses frequency range code 111b.
// - A 32.768 kHz watch crystal uses frequency range code 001b.
// - After watch crystal stabilizes, code may drop to 000 for power.
// - Enable missing-clock detector before selecting any external clock source.
// - Wait at least 1 ms after enabling before sampling valid flag.
// - First drive both crystal pins low: crossbar on, two latches cleared.
// - Second, set both crystal pins to analog input before enabling oscillator.
// - After the wait, poll the valid flag until it reads one.
// - Once valid, enable the missing-clock detector before switching.
// - Finally select the external oscillator, only after all earlier steps.
`timescale 1ns/1ns
`default_nettype none
module eos_controller #(
  parameter int unsigned SETTLE_CYCLES = eos_pkg::SETTLE_CYCLES
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic [3:0]     addr,
  input  wire logic [31:0]    wdata,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  output logic      [31:0]    rdata,
  input  wire logic           crystal_valid_flag,
  output eos_pkg::eos_dev_ctrl_t dev_ctrl
);

  // ************************************************************
  // Software registers
  // ************************************************************
  logic                 cfg_watch;
  logic                 cfg_lowp;
  logic                 start_pulse;
  logic                 abort_pulse;
  logic                 done;
  logic                 busy;
  eos_pkg::eos_state_t  state;
  eos_pkg::eos_state_t  next_state;
  logic                 timer_start;
  logic                 timer_expired;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_watch <= eos_pkg::CTRL_RESET[eos_pkg::CTRL_WATCH_BIT];
      cfg_lowp  <= eos_pkg::CTRL_RESET[eos_pkg::CTRL_LOWP_BIT];
    end else if (wr_en && addr == eos_pkg::REG_CTRL) begin
      // Crystal type changes only with no crystal in use or with a new start,
      // so a running crystal never gets another crystal's code
      if (state == eos_pkg::ST_IDLE || (done && wdata[eos_pkg::CTRL_START_BIT])) begin
        cfg_watch <= wdata[eos_pkg::CTRL_WATCH_BIT];
      end
      cfg_lowp <= wdata[eos_pkg::CTRL_LOWP_BIT];
    end
  end

  assign start_pulse = wr_en && addr == eos_pkg::REG_CTRL && wdata[eos_pkg::CTRL_START_BIT];
  assign abort_pulse = wr_en && addr == eos_pkg::REG_CTRL && wdata[eos_pkg::CTRL_ABORT_BIT];
  assign busy        = state != eos_pkg::ST_IDLE && state != eos_pkg::ST_DONE;
  assign done        = state == eos_pkg::ST_DONE;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        eos_pkg::REG_CTRL:   rdata <= {29'h0, cfg_lowp, cfg_watch, 1'b0};
        eos_pkg::REG_STATUS: rdata <= {20'h0, 4'(state), 3'h0, crystal_valid_flag, 2'h0, done, busy};
        default:             rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    next_state  = state;
    timer_start = 1'b0;
    case (state)
      eos_pkg::ST_IDLE: begin
        if (start_pulse) begin
          next_state = eos_pkg::ST_PINS_LOW;
        end
      end
      eos_pkg::ST_PINS_LOW: next_state = eos_pkg::ST_ANALOG;
      eos_pkg::ST_ANALOG:   next_state = eos_pkg::ST_ENABLE;
      eos_pkg::ST_ENABLE: begin
        timer_start = 1'b1;
        next_state  = eos_pkg::ST_WAIT;
      end
      eos_pkg::ST_WAIT: begin
        if (timer_expired) begin
          next_state = eos_pkg::ST_POLL;
        end
      end
      eos_pkg::ST_POLL: begin
        if (crystal_valid_flag) begin
          next_state = eos_pkg::ST_MCD;
        end
      end
      eos_pkg::ST_MCD:    next_state = eos_pkg::ST_SWITCH;
      eos_pkg::ST_SWITCH: next_state = eos_pkg::ST_DONE;
      eos_pkg::ST_DONE: begin
        if (start_pulse) begin
          next_state = eos_pkg::ST_PINS_LOW;
        end
      end
      default: next_state = eos_pkg::ST_IDLE;
    endcase
    // Abort keeps the old clock; too late once the switch is issued,
    // since stopping the oscillator then would starve the core
    if (abort_pulse && busy && state != eos_pkg::ST_SWITCH) begin
      next_state = eos_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= eos_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  eos_wait_timer #(
    .CYCLES (SETTLE_CYCLES)
  ) eos_wait_timer_i (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (timer_start),
    .expired (timer_expired)
  );

  // ************************************************************
  // Device control outputs
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_ctrl <= '0;
    end else begin
      case (next_state)
        eos_pkg::ST_IDLE: begin
          dev_ctrl.osc_en             <= 1'b0;
          dev_ctrl.missing_clk_det_en <= 1'b0;
          dev_ctrl.pin_a_analog       <= 1'b0;
          dev_ctrl.pin_b_analog       <= 1'b0;
        end
        eos_pkg::ST_PINS_LOW: begin
          dev_ctrl.crossbar_en      <= 1'b1;
          dev_ctrl.port0_latch_bit2 <= 1'b0;
          dev_ctrl.port0_latch_bit3 <= 1'b0;
          dev_ctrl.sysclk_sel_ext   <= 1'b0;
          // Restart from DONE walks every step again from a stopped crystal
          dev_ctrl.osc_en             <= 1'b0;
          dev_ctrl.missing_clk_det_en <= 1'b0;
          dev_ctrl.pin_a_analog       <= 1'b0;
          dev_ctrl.pin_b_analog       <= 1'b0;
        end
        eos_pkg::ST_ANALOG: begin
          dev_ctrl.pin_a_analog <= 1'b1;
          dev_ctrl.pin_b_analog <= 1'b1;
        end
        eos_pkg::ST_ENABLE: begin
          dev_ctrl.osc_en             <= 1'b1;
          dev_ctrl.ext_osc_freq_range <= cfg_watch ? eos_pkg::FREQ_WATCH_32K
                                                   : eos_pkg::FREQ_XTAL_11M;
        end
        eos_pkg::ST_MCD: dev_ctrl.missing_clk_det_en <= 1'b1;
        eos_pkg::ST_SWITCH: dev_ctrl.sysclk_sel_ext <= 1'b1;
        eos_pkg::ST_DONE: begin
          // Low power code only for a stable watch crystal
          if (cfg_watch && cfg_lowp) begin
            dev_ctrl.ext_osc_freq_range <= eos_pkg::FREQ_LOW_POWER;
          end else if (cfg_watch) begin
            dev_ctrl.ext_osc_freq_range <= eos_pkg::FREQ_WATCH_32K;
          end
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_pins_ready;
    dev_ctrl.crossbar_en && !dev_ctrl.port0_latch_bit2 && !dev_ctrl.port0_latch_bit3;
  endsequence

  sequence s_armed;
    dev_ctrl.missing_clk_det_en && dev_ctrl.osc_en;
  endsequence

  // Front steps: pins low, then analog, then oscillator on
  sequence s_front_steps;
    s_pins_ready ##1 (dev_ctrl.pin_a_analog && dev_ctrl.pin_b_analog) ##1 dev_ctrl.osc_en;
  endsequence

  // Hand-over: detector first, external clock one cycle later
  sequence s_hand_over;
    dev_ctrl.missing_clk_det_en ##1 (dev_ctrl.missing_clk_det_en && dev_ctrl.sysclk_sel_ext);
  endsequence

  // Oscillator-on cycles, counted apart from the wait timer
  localparam int unsigned CW = eos_pkg::CNT_W;
  logic [CW-1:0] osc_on_cycles;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_on_cycles <= '0;
    end else if (!dev_ctrl.osc_en) begin
      osc_on_cycles <= '0;
    end else if (osc_on_cycles != '1) begin
      osc_on_cycles <= osc_on_cycles + 1'b1;
    end
  end

  AST_SWITCH_NEEDS_MCD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_ctrl.sysclk_sel_ext) |-> s_armed and $past(dev_ctrl.missing_clk_det_en))
    else $error("clock switched without missing-clock detector");

  AST_ANALOG_AFTER_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_ctrl.pin_a_analog) |-> s_pins_ready and !dev_ctrl.osc_en)
    else $error("analog mode set before pins forced low");

  AST_PINS_LOW_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !busy && start_pulse |=> s_front_steps)
    else $error("pins not forced low as first step");

  AST_WAIT_MIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_WAIT && next_state == eos_pkg::ST_POLL |-> osc_on_cycles >= CW'(SETTLE_CYCLES))
    else $error("valid flag sampled before settling wait");

  AST_POLL_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_POLL && !crystal_valid_flag && !abort_pulse |=> state == eos_pkg::ST_POLL)
    else $error("left polling without valid flag");

  AST_MCD_ON_VALID: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_POLL && crystal_valid_flag && !abort_pulse |=> s_hand_over)
    else $error("detector not armed on valid flag");

  AST_FREQ_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_ctrl.osc_en)
      |-> dev_ctrl.ext_osc_freq_range == (cfg_watch ? eos_pkg::FREQ_WATCH_32K : eos_pkg::FREQ_XTAL_11M))
    else $error("wrong frequency range code");

  AST_LOWP_WATCH_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_ctrl.osc_en && dev_ctrl.ext_osc_freq_range == eos_pkg::FREQ_LOW_POWER
      |-> cfg_watch && dev_ctrl.sysclk_sel_ext)
    else $error("low power code without stable watch crystal");

  AST_SWITCH_LAST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_ctrl.sysclk_sel_ext |-> dev_ctrl.pin_a_analog && dev_ctrl.pin_b_analog && dev_ctrl.crossbar_en)
    else $error("clock switched before earlier steps");

  // ************************************************************
  // Checks on step order and held controls
  // ************************************************************
  AST_ENABLE_AFTER_ANALOG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_ctrl.osc_en) |-> s_pins_ready and (dev_ctrl.pin_a_analog && dev_ctrl.pin_b_analog))
    else $error("oscillator enabled before pins set to analog");

  AST_PINS_STAY_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_ctrl.osc_en |-> s_pins_ready)
    else $error("crystal pins released while oscillator runs");

  AST_ANALOG_IN_ENABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_ENABLE |-> dev_ctrl.pin_a_analog && dev_ctrl.pin_b_analog && !dev_ctrl.missing_clk_det_en)
    else $error("enable step reached without analog pins");

  AST_TIMER_REARMED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_ENABLE |=> !timer_expired)
    else $error("settling timer not restarted");

  AST_POLL_FROM_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_POLL && $past(state) != eos_pkg::ST_POLL |-> $past(state) == eos_pkg::ST_WAIT)
    else $error("polling entered without the wait");

  AST_MCD_FROM_POLL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_MCD
      |-> $past(state) == eos_pkg::ST_POLL && $past(crystal_valid_flag))
    else $error("detector step without a valid flag");

  AST_FREQ_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_ctrl.osc_en && $past(dev_ctrl.osc_en) && !dev_ctrl.sysclk_sel_ext |-> $stable(dev_ctrl.ext_osc_freq_range))
    else $error("frequency code changed during start-up");

  AST_CODE_11M_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_DONE && !cfg_watch |-> dev_ctrl.ext_osc_freq_range == eos_pkg::FREQ_XTAL_11M)
    else $error("fast crystal lost its code");

  AST_WATCH_CODE_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_DONE && cfg_watch && !start_pulse
      |=> dev_ctrl.ext_osc_freq_range == ($past(cfg_lowp) ? eos_pkg::FREQ_LOW_POWER : eos_pkg::FREQ_WATCH_32K))
    else $error("watch crystal code wrong after switch");

  // ************************************************************
  // Checks on the hand-over and the old clock
  // ************************************************************
  AST_DET_BEFORE_EXT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_ctrl.missing_clk_det_en) |-> !dev_ctrl.sysclk_sel_ext)
    else $error("detector armed after the switch");

  AST_DET_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dev_ctrl.sysclk_sel_ext |-> dev_ctrl.missing_clk_det_en && dev_ctrl.osc_en)
    else $error("external clock without detector or oscillator");

  AST_SWITCH_AFTER_VALID: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(dev_ctrl.sysclk_sel_ext) |-> $past(crystal_valid_flag, 2))
    else $error("clock switched without a valid flag");

  AST_NO_EXT_WHILE_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busy && state != eos_pkg::ST_SWITCH |-> !dev_ctrl.sysclk_sel_ext)
    else $error("external clock selected mid-sequence");

  AST_SWITCH_THEN_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_SWITCH |=> state == eos_pkg::ST_DONE)
    else $error("switch step did not finish");

  AST_IDLE_OLD_CLOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state == eos_pkg::ST_IDLE |-> !dev_ctrl.sysclk_sel_ext && !dev_ctrl.osc_en)
    else $error("idle with external clock or oscillator on");

  AST_START_IGNORED_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busy && !abort_pulse |=> state != eos_pkg::ST_PINS_LOW)
    else $error("start taken while busy");

  AST_ABORT_TO_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    abort_pulse && busy && state != eos_pkg::ST_SWITCH
      |=> state == eos_pkg::ST_IDLE && !dev_ctrl.osc_en && !dev_ctrl.missing_clk_det_en && !dev_ctrl.pin_a_analog)
    else $error("abort did not stop the sequence");

  AST_RDATA_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rd_en |=> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule
`default_nettype wire

// [eos_osc_model.sv]
// Behavioural external crystal with its amplitude-valid detector
`timescale 1ns/1ns
`default_nettype none
module eos_osc_model (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire eos_pkg::eos_dev_ctrl_t dev_ctrl,
  input  wire logic [15:0]            valid_delay,
  output logic                        crystal_valid_flag,
  output logic                        runs_on_ext
);
  logic [15:0] amp_cnt;

  // ************************************************************
  // Amplitude build-up
  // ************************************************************
  // Grows only while the oscillator is on; saturates
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_cnt <= 16'h0000;
    end else if (!dev_ctrl.osc_en) begin
      amp_cnt <= 16'h0000;
    end else if (amp_cnt != 16'hFFFF) begin
      amp_cnt <= amp_cnt + 16'h0001;
    end
  end

  // Pins must be analog too, or the crystal never swings
  assign crystal_valid_flag = dev_ctrl.osc_en && dev_ctrl.pin_a_analog && dev_ctrl.pin_b_analog
                              && (amp_cnt >= valid_delay);
  // Core keeps the old clock until the final switch
  assign runs_on_ext = dev_ctrl.sysclk_sel_ext;
endmodule
`default_nettype wire

// [eos_controller_tb.sv]
// Self-checking testbench for the oscillator start-up controller
`timescale 1ns/1ns
`default_nettype none
module eos_controller_tb;
  localparam int unsigned SETTLE = 20;

  logic                   ref_clk;
  logic                   rst_n;
  logic [3:0]             addr;
  logic [31:0]            wdata;
  logic                   wr_en;
  logic                   rd_en;
  logic [31:0]            rdata;
  logic                   crystal_valid_flag;
  logic                   runs_on_ext;
  logic [15:0]            valid_delay;
  eos_pkg::eos_dev_ctrl_t dev_ctrl;
  int                     bad_count;
  int                     total_checks;
  int                     cyc;
  logic [31:0]            rv;

  eos_controller #(.SETTLE_CYCLES(SETTLE)) eos_controller_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .crystal_valid_flag(crystal_valid_flag), .dev_ctrl(dev_ctrl));
  eos_osc_model eos_osc_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .dev_ctrl(dev_ctrl), .valid_delay(valid_delay),
    .crystal_valid_flag(crystal_valid_flag), .runs_on_ext(runs_on_ext));

  // ************************************************************
  // Clock, timeout and bus tasks
  // ************************************************************
  always #10 ref_clk = ~ref_clk;

  // Whole run needs about a hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask

  // ************************************************************
  // Full start-up walk
  // ************************************************************
  task automatic run_seq(input logic [31:0] cmd, input logic [15:0] dly, input logic [2:0] code,
                         input logic [2:0] fin);
    int n;
    n = 0;
    valid_delay = dly;
    wr(eos_pkg::REG_CTRL, cmd);
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(dev_ctrl.crossbar_en === 1'b1 && dev_ctrl.pin_a_analog === 1'b0 && dev_ctrl.osc_en === 1'b0
                 && runs_on_ext === 1'b0) && n < 4);
    chk("pins_low", 32'({dev_ctrl.crossbar_en, dev_ctrl.port0_latch_bit2, dev_ctrl.port0_latch_bit3,
        dev_ctrl.pin_a_analog, dev_ctrl.pin_b_analog, dev_ctrl.osc_en, runs_on_ext}), 32'h40);
    @(negedge ref_clk);
    chk("analog", 32'({dev_ctrl.pin_a_analog, dev_ctrl.pin_b_analog, dev_ctrl.osc_en}), 32'h6);
    @(negedge ref_clk);
    chk("osc_on", 32'({dev_ctrl.osc_en, dev_ctrl.ext_osc_freq_range}), 32'({1'b1, code}));
    n = 0;
    while (dev_ctrl.missing_clk_det_en !== 1'b1 && n < 200) begin
      chk("old_clk", 32'(runs_on_ext), 32'h0);
      @(negedge ref_clk);
      n++;
    end
    chk("wait_len", 32'(n >= SETTLE && n >= dly && n < 200), 32'h1);
    chk("det_first", 32'({crystal_valid_flag, runs_on_ext}), 32'h2);
    @(negedge ref_clk);
    chk("switched", 32'({dev_ctrl.missing_clk_det_en, runs_on_ext}), 32'h3);
    repeat (2) @(negedge ref_clk);
    chk("final_code", 32'(dev_ctrl.ext_osc_freq_range), 32'(fin));
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    valid_delay = 16'h0003;
    bad_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (4) @(posedge ref_clk);
    chk("reset_ctrl", 32'(dev_ctrl), 32'h0);
    rst_n <= 1'b1;
    rd(4'hF, rv);
    chk("unmapped", rv, 32'h0);
    // Early valid flag must not shorten the wait
    run_seq(32'h1, 16'h0003, eos_pkg::FREQ_XTAL_11M, eos_pkg::FREQ_XTAL_11M);
    rd(eos_pkg::REG_STATUS, rv);
    chk("status_done", rv, 32'h0000_0812);
    // Watch bit without start must not re-code a running crystal
    wr(eos_pkg::REG_CTRL, 32'h2);
    repeat (2) @(negedge ref_clk);
    chk("code_kept", 32'(dev_ctrl.ext_osc_freq_range), 32'(eos_pkg::FREQ_XTAL_11M));
    // Slow crystal from DONE: polling must hold off
    run_seq(32'h7, 16'h0028, eos_pkg::FREQ_WATCH_32K, eos_pkg::FREQ_LOW_POWER);
    rd(eos_pkg::REG_CTRL, rv);
    chk("ctrl_read", rv, 32'h0000_0006);
    wr(eos_pkg::REG_CTRL, 32'h1);
    repeat (6) @(negedge ref_clk);
    wr(eos_pkg::REG_CTRL, 32'h8);
    repeat (2) @(negedge ref_clk);
    chk("abort", 32'({dev_ctrl.osc_en, dev_ctrl.missing_clk_det_en, dev_ctrl.pin_a_analog, runs_on_ext}),
        32'h0);
    rd(eos_pkg::REG_STATUS, rv);
    chk("abort_idle", rv & 32'h0000_0F01, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
